// >>> hdl/eepc_top.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module eepc_top #(
  parameter bit LVI_PRESENT = 1'b1,
  parameter int PULSE_CYC   = eepc_pkg::PULSE_CYC
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [11:0] awaddr,
  // write data
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // read address
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [11:0] araddr,
  // read data
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // pins
  input  wire logic        lvi_detect,
  input  wire logic        prog_allow_pin,
  // array power and clock
  output logic             pump_running,
  output logic             hv_applied,
  output logic             array_rc_clock_sel,
  output logic             low_volt_inhibit
);

  // ****************************************
  // state and pin synchronisers
  // ****************************************
  eepc_pkg::eepc_state_s s_r;
  eepc_pkg::eepc_state_s s_nxt;
  eepc_pkg::eepc_state_s rst_state;
  logic                  lvi_s;
  logic                  allow_s;
  logic                  fire;
  logic                  aw_ctrl;
  logic                  aw_arr;
  logic                  ar_ctrl;
  logic                  ar_arr;
  logic                  w_any;
  logic [6:0]            w_idx;
  logic [7:0]            w_byte;

  // resets to the inhibit level so no false release follows reset
  eepc_sync2 #(
    .RST_VAL (1'b1)
  ) u_sync_lvi (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (lvi_detect),
    .q       (lvi_s)
  );

  eepc_sync2 u_sync_allow (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (prog_allow_pin),
    .q       (allow_s)
  );

  eepc_pulse_timer #(
    .CYC (PULSE_CYC)
  ) u_pulse (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (s_r.ctrl.prog_power && s_r.latched && !s_r.done),
    .fire    (fire)
  );

  // ****************************************
  // address decode
  // ****************************************
  assign aw_ctrl = (awaddr[11:2] == eepc_pkg::CTRL_OFF[11:2]);
  assign aw_arr  = (awaddr[11:7] == eepc_pkg::ARRAY_BASE[11:7]);
  assign ar_ctrl = (araddr[11:2] == eepc_pkg::CTRL_OFF[11:2]);
  assign ar_arr  = (araddr[11:7] == eepc_pkg::ARRAY_BASE[11:7]);
  assign w_any   = |wstrb;

  // lowest enabled lane picks the single byte
  always_comb begin
    w_idx  = {awaddr[6:2], 2'h3};
    w_byte = wdata[31:24];
    if (wstrb[0]) begin
      w_idx  = {awaddr[6:2], 2'h0};
      w_byte = wdata[7:0];
    end else if (wstrb[1]) begin
      w_idx  = {awaddr[6:2], 2'h1};
      w_byte = wdata[15:8];
    end else if (wstrb[2]) begin
      w_idx  = {awaddr[6:2], 2'h2};
      w_byte = wdata[23:16];
    end
  end

  always_comb begin
    rst_state              = '0;
    rst_state.st           = eepc_pkg::EEPC_IDLE;
    rst_state.ctrl         = LVI_PRESENT ? eepc_pkg::CTRL_RST_LVI
                                         : eepc_pkg::CTRL_RST_NO;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    // bus handshakes
    case (s_r.st)
      eepc_pkg::EEPC_IDLE: begin
        if (s_r.awready) begin
          s_nxt.awready = 1'b0;
          s_nxt.wready  = 1'b0;
          s_nxt.bvalid  = 1'b1;
          s_nxt.bresp   = eepc_pkg::RESP_OKAY;
          s_nxt.st      = eepc_pkg::EEPC_WRSP;
          if (aw_ctrl) begin
            if (wstrb[0] && !s_r.ctrl.inhibit) begin
              s_nxt.ctrl.pump_en   = wdata[eepc_pkg::BIT_PUMP];
              s_nxt.ctrl.erase_sel = wdata[eepc_pkg::BIT_ERASE_HI:eepc_pkg::BIT_ERASE_LO];
              s_nxt.ctrl.capture   = wdata[eepc_pkg::BIT_CAPTURE];
              s_nxt.ctrl.rc_sel    = wdata[eepc_pkg::BIT_RC_SEL];
              if (s_r.ctrl.capture) begin
                s_nxt.ctrl.prog_power = wdata[eepc_pkg::BIT_POWER] &&
                                        (allow_s || s_r.ctrl.prog_power);
              end
              if (!wdata[eepc_pkg::BIT_POWER]) begin
                s_nxt.done = 1'b0;
              end
            end
          end else if (aw_arr) begin
            if (s_r.ctrl.capture && w_any && !s_r.ctrl.prog_power) begin
              s_nxt.latched  = 1'b1;
              s_nxt.done     = 1'b0;
              s_nxt.lat_addr = w_idx;
              s_nxt.lat_data = w_byte;
            end
          end else begin
            s_nxt.bresp = eepc_pkg::RESP_SLVERR;
          end
        end else if (s_r.arready) begin
          s_nxt.arready = 1'b0;
          s_nxt.rvalid  = 1'b1;
          s_nxt.rresp   = eepc_pkg::RESP_OKAY;
          s_nxt.rdata   = '0;
          s_nxt.st      = eepc_pkg::EEPC_RRSP;
          if (ar_ctrl) begin
            s_nxt.rdata[7:0] = s_r.ctrl;
          end else if (ar_arr) begin
            if (!(s_r.ctrl.capture && s_r.latched)) begin
              for (int k = 0; k < 4; k++) begin
                s_nxt.rdata[8*k +: 8] = s_r.mem[{araddr[6:2], 2'(k)}];
              end
            end
          end else begin
            s_nxt.rresp = eepc_pkg::RESP_SLVERR;
          end
        end else if (awvalid && wvalid) begin
          s_nxt.awready = 1'b1;
          s_nxt.wready  = 1'b1;
        end else if (arvalid) begin
          s_nxt.arready = 1'b1;
        end
      end
      eepc_pkg::EEPC_WRSP: begin
        if (bready) begin
          s_nxt.bvalid = 1'b0;
          s_nxt.st     = eepc_pkg::EEPC_IDLE;
        end
      end
      eepc_pkg::EEPC_RRSP: begin
        if (rready) begin
          s_nxt.rvalid = 1'b0;
          s_nxt.st     = eepc_pkg::EEPC_IDLE;
        end
      end
      default: begin
        s_nxt = rst_state;
      end
    endcase

    // program or erase once the pulse has run its time
    if (fire && s_r.ctrl.prog_power) begin
      s_nxt.done = 1'b1;
      case (s_r.ctrl.erase_sel)
        eepc_pkg::ERASE_NONE: begin
          s_nxt.mem[s_r.lat_addr] = s_r.mem[s_r.lat_addr] | s_r.lat_data;
        end
        eepc_pkg::ERASE_BYTE: begin
          s_nxt.mem[s_r.lat_addr] = eepc_pkg::ERASED_BYTE;
        end
        eepc_pkg::ERASE_BLOCK: begin
          for (int j = 0; j < eepc_pkg::BLOCK_BYTES; j++) begin
            s_nxt.mem[{s_r.lat_addr[6:5], 5'(j)}] = eepc_pkg::ERASED_BYTE;
          end
        end
        default: begin
          for (int j = 0; j < eepc_pkg::ARRAY_BYTES; j++) begin
            s_nxt.mem[j] = eepc_pkg::ERASED_BYTE;
          end
        end
      endcase
    end

    // low-voltage inhibit, free running in every power mode
    s_nxt.ctrl.inhibit = LVI_PRESENT && lvi_s;
    s_nxt.ctrl.rsvd    = 1'b0;
    if (s_nxt.ctrl.inhibit) begin
      s_nxt.ctrl[6:0] = '0;
    end
    if (!s_nxt.ctrl.capture) begin
      s_nxt.latched = 1'b0;
    end
    s_nxt.pump_running = s_nxt.ctrl.pump_en || s_nxt.ctrl.prog_power;
    s_nxt.hv_applied   = s_nxt.ctrl.prog_power;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= rst_state;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign awready            = s_r.awready;
  assign wready             = s_r.wready;
  assign bvalid             = s_r.bvalid;
  assign bresp              = s_r.bresp;
  assign arready            = s_r.arready;
  assign rvalid             = s_r.rvalid;
  assign rdata              = s_r.rdata;
  assign rresp              = s_r.rresp;
  assign pump_running       = s_r.pump_running;
  assign hv_applied         = s_r.hv_applied;
  assign array_rc_clock_sel = s_r.ctrl.rc_sel;
  assign low_volt_inhibit   = s_r.ctrl.inhibit;

  // ****************************************
  // assertions
  // ****************************************
  property p_inhibit_clears;
    @(posedge aclk) disable iff (!aresetn)
    s_r.ctrl.inhibit |-> (s_r.ctrl[6:0] == 7'h00) && !hv_applied && !pump_running;
  endproperty
  a_inhibit_clears: assert property (p_inhibit_clears)
    else $error("control bits not cleared under inhibit");

  property p_inhibit_follows;
    @(posedge aclk) disable iff (!aresetn)
    lvi_s |=> low_volt_inhibit == LVI_PRESENT;
  endproperty
  a_inhibit_follows: assert property (p_inhibit_follows)
    else $error("inhibit does not follow detector");

  property p_no_option;
    @(posedge aclk) disable iff (!aresetn)
    !LVI_PRESENT |-> !s_r.ctrl.inhibit;
  endproperty
  a_no_option: assert property (p_no_option)
    else $error("bit 7 set without inhibit option");

  property p_power_needs_capture;
    @(posedge aclk) disable iff (!aresetn)
    $rose(s_r.ctrl.prog_power) |-> $past(s_r.ctrl.capture) && $past(allow_s);
  endproperty
  a_power_needs_capture: assert property (p_power_needs_capture)
    else $error("power set without prior capture or allow");

  property p_hv_with_pump;
    @(posedge aclk) disable iff (!aresetn)
    hv_applied |-> pump_running;
  endproperty
  a_hv_with_pump: assert property (p_hv_with_pump)
    else $error("array voltage without pump");

  property p_read_blocked;
    @(posedge aclk) disable iff (!aresetn)
    (s_r.st == eepc_pkg::EEPC_IDLE && arready && ar_arr && s_r.ctrl.capture
     && s_r.latched) |=> rvalid && (rdata == 32'h0);
  endproperty
  a_read_blocked: assert property (p_read_blocked)
    else $error("array read not blocked");

  property p_latch_write;
    @(posedge aclk) disable iff (!aresetn)
    (awready && aw_arr && s_r.ctrl.capture && !s_r.ctrl.prog_power && wstrb[0]
     && !lvi_s) |=> s_r.latched && (s_r.lat_data == $past(wdata[7:0])) && bvalid;
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("array write not latched");

  property p_bulk;
    @(posedge aclk) disable iff (!aresetn)
    (fire && s_r.ctrl.prog_power && s_r.ctrl.erase_sel == eepc_pkg::ERASE_BULK)
      |=> (s_r.mem == '0);
  endproperty
  a_bulk: assert property (p_bulk)
    else $error("bulk erase incomplete");

  property p_write_answer;
    @(posedge aclk) disable iff (!aresetn)
    (s_r.st == eepc_pkg::EEPC_IDLE && awvalid && wvalid && !awready && !arready)
      |=> awready ##1 bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write not answered in two cycles");

  c_program: cover property (@(posedge aclk) disable iff (!aresetn)
    fire && s_r.ctrl.erase_sel == eepc_pkg::ERASE_NONE);
  c_block: cover property (@(posedge aclk) disable iff (!aresetn)
    fire && s_r.ctrl.erase_sel == eepc_pkg::ERASE_BLOCK);
  c_inhibit: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(low_volt_inhibit));

endmodule
`default_nettype wire

// >>> hdl/eepc_pkg.sv
`default_nettype none
package eepc_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] CTRL_OFF     = 12'h01c;
  localparam logic [11:0] ARRAY_BASE   = 12'h100;
  localparam int          ARRAY_BYTES  = 128;
  localparam int          ARRAY_AW     = 7;
  localparam int          BLOCK_BYTES  = 32;

  // ****************************************
  // control register fields and reset
  // ****************************************
  localparam int          BIT_INHIBIT  = 7;
  localparam int          BIT_PUMP     = 6;
  localparam int          BIT_ERASE_HI = 4;
  localparam int          BIT_ERASE_LO = 3;
  localparam int          BIT_CAPTURE  = 2;
  localparam int          BIT_RC_SEL   = 1;
  localparam int          BIT_POWER    = 0;
  localparam logic [7:0]  CTRL_RST_LVI = 8'h80;
  localparam logic [7:0]  CTRL_RST_NO  = 8'h00;
  localparam logic [7:0]  ERASED_BYTE  = 8'h00;

  // ****************************************
  // erase modes
  // ****************************************
  localparam logic [1:0]  ERASE_NONE   = 2'h0;
  localparam logic [1:0]  ERASE_BYTE   = 2'h1;
  localparam logic [1:0]  ERASE_BLOCK  = 2'h2;
  localparam logic [1:0]  ERASE_BULK   = 2'h3;

  // ****************************************
  // bus answers
  // ****************************************
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_NS       = 50;
  localparam int          PULSE_NS     = 10000;
  localparam int          PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    EEPC_IDLE = 3'h1,
    EEPC_WRSP = 3'h2,
    EEPC_RRSP = 3'h4
  } eepc_bus_e;

  typedef struct packed {
    logic       inhibit;
    logic       pump_en;
    logic       rsvd;
    logic [1:0] erase_sel;
    logic       capture;
    logic       rc_sel;
    logic       prog_power;
  } eepc_ctrl_s;

  typedef struct packed {
    logic meta;
    logic stable;
  } eepc_sync_s;

  typedef struct packed {
    eepc_bus_e                   st;
    logic                        awready;
    logic                        wready;
    logic                        arready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;
    eepc_ctrl_s                  ctrl;
    logic                        latched;
    logic                        done;
    logic [6:0]                  lat_addr;
    logic [7:0]                  lat_data;
    logic                        pump_running;
    logic                        hv_applied;
    logic [127:0][7:0]           mem;
  } eepc_state_s;

endpackage
`default_nettype wire

// >>> hdl/eepc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module eepc_sync2 #(
  parameter bit RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // level in and out
  input  wire logic d,
  output logic      q
);

  eepc_pkg::eepc_sync_s s_r;
  eepc_pkg::eepc_sync_s s_nxt;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.meta   = d;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= {RST_VAL, RST_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.stable;

endmodule
`default_nettype wire

// >>> hdl/eepc_pulse_timer.sv
`timescale 1ns/1ps
`default_nettype none
module eepc_pulse_timer #(
  parameter int CYC = 200
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // control
  input  wire logic run,
  output logic      fire
);

  localparam int CW = $clog2(CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          fire;
  } eepc_tmr_s;

  eepc_tmr_s s_r;
  eepc_tmr_s s_nxt;

  // counts while run, one pulse after CYC cycles
  always_comb begin
    s_nxt      = s_r;
    s_nxt.fire = 1'b0;
    if (!run) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt != CW'(CYC)) begin
      s_nxt.cnt  = s_r.cnt + CW'(1);
      s_nxt.fire = (s_r.cnt == CW'(CYC - 1));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fire = s_r.fire;

endmodule
`default_nettype wire

// >>> sim/eepc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// cpu side register bus master
// ****************************************
module eepc_cpu_model (
  // clock
  input  wire logic        aclk,
  // write channels
  output logic             awvalid,
  input  wire logic        awready,
  output logic [11:0]      awaddr,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  // read channels
  output logic             arvalid,
  input  wire logic        arready,
  output logic [11:0]      araddr,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr} = 24'hffffff;
    wdata = 32'hffffffff;
    wstrb = 4'h0;
  end

  // released addresses and write data show the inverse, never the old value; wstrb keeps the old value
  task automatic write32(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r, output bit ok);
    bit aw_done;
    bit w_done;
    {aw_done, w_done, ok} = 3'b000;
    r = 2'h3;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
      if (bvalid) begin
        r = bresp;
        ok = 1'b1;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic read32(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r, output bit ok);
    bit a_done;
    {a_done, ok} = 2'b00;
    r = 2'h3;
    d = 32'h0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge aclk);
      if (!a_done && arready) begin
        a_done = 1'b1;
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
      if (rvalid) begin
        {d, r} = {rdata, rresp};
        ok = 1'b1;
        rready <= 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/eepc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eepc_top_tb;
  // ****************************************
  // clock, pins, bus wires
  // ****************************************
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        lvi_detect = 1'b1;
  logic        prog_allow_pin = 1'b1;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        pump_running, hv_applied, array_rc_clock_sel, low_volt_inhibit;
  logic        lvi_off;
  logic [7:0]  exp_mem [128];
  int          err_count = 0;
  int          cmp_count = 0;

  always #25 aclk = ~aclk;

  eepc_top #(.LVI_PRESENT(1'b1), .PULSE_CYC(4)) eepc_top_i (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .lvi_detect(lvi_detect), .prog_allow_pin(prog_allow_pin), .pump_running(pump_running),
    .hv_applied(hv_applied), .array_rc_clock_sel(array_rc_clock_sel),
    .low_volt_inhibit(low_volt_inhibit));

  // second build without the inhibit option, bus idle
  eepc_top #(.LVI_PRESENT(1'b0), .PULSE_CYC(4)) eepc_top_i2 (
    .aclk(aclk), .aresetn(aresetn), .awvalid(1'b0), .awready(), .awaddr(12'h000),
    .wvalid(1'b0), .wready(), .wdata(32'h0), .wstrb(4'h0), .bvalid(), .bready(1'b0),
    .bresp(), .arvalid(1'b0), .arready(), .araddr(12'h000), .rvalid(), .rready(1'b0),
    .rdata(), .rresp(), .lvi_detect(lvi_detect), .prog_allow_pin(prog_allow_pin),
    .pump_running(), .hv_applied(), .array_rc_clock_sel(), .low_volt_inhibit(lvi_off));

  eepc_cpu_model eepc_cpu_model_i (
    .aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp));

  // ****************************************
  // compare and bus helpers
  // ****************************************
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_val(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic [1:0] r;
    bit         ok;
    eepc_cpu_model_i.write32(a, d, s, r, ok);
    chk_bit("write done", 1'b1, ok);
    if (!ok) complete_run();
    else chk_val("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    bit          ok;
    eepc_cpu_model_i.read32(a, d, r, ok);
    chk_bit("read done", 1'b1, ok);
    if (!ok) begin
      complete_run();
    end else begin
      chk_val("rresp", {30'h0, er}, {30'h0, r});
      if (er == eepc_pkg::RESP_OKAY) chk_val("rdata", e, d);
    end
  endtask

  task automatic wait_inh(input logic v);
    for (int n = 0; n < 16 && low_volt_inhibit !== v; n++) @(posedge aclk);
    chk_bit("inhibit level", v, low_volt_inhibit);
    if (low_volt_inhibit !== v) complete_run();
  endtask

  task automatic chk_words();
    for (int w = 0; w < 128; w += 4)
      rd_chk(eepc_pkg::ARRAY_BASE + 12'(w), {exp_mem[w+3], exp_mem[w+2], exp_mem[w+1],
             exp_mem[w]}, eepc_pkg::RESP_OKAY);
  endtask

  // one program or erase pass, model updated alongside
  task automatic do_op(input logic [1:0] m, input logic [6:0] off, input logic [7:0] d);
    logic [11:0] wa;
    wa = eepc_pkg::ARRAY_BASE + {5'h0, off[6:2], 2'b00};
    wr(eepc_pkg::CTRL_OFF, {24'h0, 3'b010, m, 3'b100}, 4'h1, eepc_pkg::RESP_OKAY);
    wr(wa, {24'h0, d} << (8 * off[1:0]), 4'h1 << off[1:0], eepc_pkg::RESP_OKAY);
    rd_chk(wa, 32'h0, eepc_pkg::RESP_OKAY);
    chk_bit("hv before power", 1'b0, hv_applied);
    wr(eepc_pkg::CTRL_OFF, {24'h0, 3'b010, m, 3'b101}, 4'h1, eepc_pkg::RESP_OKAY);
    chk_bit("hv applied", 1'b1, hv_applied);
    repeat (8) @(posedge aclk);
    wr(eepc_pkg::CTRL_OFF, {24'h0, 3'b010, m, 3'b100}, 4'h1, eepc_pkg::RESP_OKAY);
    chk_bit("hv removed", 1'b0, hv_applied);
    wr(eepc_pkg::CTRL_OFF, 32'h0, 4'h1, eepc_pkg::RESP_OKAY);
    for (int i = 0; i < 128; i++)
      case (m)
        eepc_pkg::ERASE_NONE:  if (i == off) exp_mem[i] = exp_mem[i] | d;
        eepc_pkg::ERASE_BYTE:  if (i == off) exp_mem[i] = eepc_pkg::ERASED_BYTE;
        eepc_pkg::ERASE_BLOCK: if (i[6:5] == off[6:5]) exp_mem[i] = eepc_pkg::ERASED_BYTE;
        default:               exp_mem[i] = eepc_pkg::ERASED_BYTE;
      endcase
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic scn_ctrl();
    wr(eepc_pkg::CTRL_OFF, 32'h7f, 4'h1, eepc_pkg::RESP_OKAY);
    rd_chk(eepc_pkg::CTRL_OFF, 32'h5e, eepc_pkg::RESP_OKAY);
    chk_bit("pump", 1'b1, pump_running);
    chk_bit("rc sel", 1'b1, array_rc_clock_sel);
    chk_bit("hv off", 1'b0, hv_applied);
    wr(eepc_pkg::CTRL_OFF, 32'h0, 4'h1, eepc_pkg::RESP_OKAY);
    rd_chk(eepc_pkg::CTRL_OFF, 32'h0, eepc_pkg::RESP_OKAY);
  endtask

  task automatic scn_program_erase();
    do_op(eepc_pkg::ERASE_NONE, 7'h00, 8'ha1);
    do_op(eepc_pkg::ERASE_NONE, 7'h01, 8'hb2);
    do_op(eepc_pkg::ERASE_NONE, 7'h21, 8'hc3);
    do_op(eepc_pkg::ERASE_NONE, 7'h41, 8'hd4);
    do_op(eepc_pkg::ERASE_NONE, 7'h7e, 8'he5);
    chk_words();
    do_op(eepc_pkg::ERASE_BYTE, 7'h00, 8'hff);
    chk_words();
    do_op(eepc_pkg::ERASE_BLOCK, 7'h25, 8'hff);
    chk_words();
    do_op(eepc_pkg::ERASE_BULK, 7'h41, 8'hff);
    chk_words();
  endtask

  task automatic scn_allow_pin();
    prog_allow_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    wr(eepc_pkg::CTRL_OFF, 32'h44, 4'h1, eepc_pkg::RESP_OKAY);
    wr(eepc_pkg::CTRL_OFF, 32'h45, 4'h1, eepc_pkg::RESP_OKAY);
    rd_chk(eepc_pkg::CTRL_OFF, 32'h44, eepc_pkg::RESP_OKAY);
    chk_bit("hv blocked", 1'b0, hv_applied);
    prog_allow_pin <= 1'b1;
    wr(eepc_pkg::CTRL_OFF, 32'h0, 4'h1, eepc_pkg::RESP_OKAY);
  endtask

  task automatic scn_inhibit();
    wr(eepc_pkg::CTRL_OFF, 32'h5e, 4'h1, eepc_pkg::RESP_OKAY);
    lvi_detect <= 1'b1;
    wait_inh(1'b1);
    chk_bit("pump cut", 1'b0, pump_running);
    chk_bit("rc cut", 1'b0, array_rc_clock_sel);
    chk_bit("no option bit 7", 1'b0, lvi_off);
    rd_chk(eepc_pkg::CTRL_OFF, 32'h80, eepc_pkg::RESP_OKAY);
    wr(eepc_pkg::CTRL_OFF, 32'h40, 4'h1, eepc_pkg::RESP_OKAY);
    rd_chk(eepc_pkg::CTRL_OFF, 32'h80, eepc_pkg::RESP_OKAY);
    lvi_detect <= 1'b0;
    wait_inh(1'b0);
    rd_chk(eepc_pkg::CTRL_OFF, 32'h0, eepc_pkg::RESP_OKAY);
    wr(eepc_pkg::CTRL_OFF, 32'h00, 4'h1, eepc_pkg::RESP_OKAY);
  endtask

  task automatic scn_unmapped();
    wr(12'h020, 32'h5e, 4'h1, eepc_pkg::RESP_SLVERR);
    rd_chk(12'h200, 32'h0, eepc_pkg::RESP_SLVERR);
    rd_chk(eepc_pkg::CTRL_OFF, 32'h0, eepc_pkg::RESP_OKAY);
  endtask

  initial begin
    for (int i = 0; i < 128; i++) exp_mem[i] = eepc_pkg::ERASED_BYTE;
    repeat (8) @(posedge aclk);
    chk_bit("inhibit in reset", 1'b1, low_volt_inhibit);
    chk_bit("no option bit 7", 1'b0, lvi_off);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk_bit("inhibit after reset", 1'b1, low_volt_inhibit);
    lvi_detect <= 1'b0;
    wait_inh(1'b0);
    rd_chk(eepc_pkg::CTRL_OFF, 32'h0, eepc_pkg::RESP_OKAY);
    scn_ctrl();
    scn_program_erase();
    scn_allow_pin();
    scn_inhibit();
    scn_unmapped();
    complete_run();
  end
endmodule
`default_nettype wire
